// ### common/rsr_cfg.svh
// Offsets, field positions, reset values and codes of the settings report block
// What this block does
// (R1) The response starts with the echoed request code in byte 0 and success status in byte 1.
// (R2) Byte 6 bits 7-6 hold the DAC reference level: 11 4.096 V, 10 2.048 V, 01 1.024 V, 00 off.
// (R3) Byte 6 bit 5 is 1 for the internal voltage reference as DAC source, 0 for the supply.
// (R4) Byte 6 bits 4-0 hold the five-bit power-up DAC code.
// (R5) With byte 7 bit 6 set, each falling edge of the interrupt input sets the detect flag.
// (R6) With byte 7 bit 5 set, each rising edge sets the flag; both enables may be on together.
// (R7) Byte 7 bits 4-3 hold the ADC reference level in the same code; 4.096 V needs a higher supply.
// (R8) Byte 7 bit 2 is 1 for the internal ADC reference, 0 for the supply rail.
// (R9) The vendor identifier goes low byte in byte 8, high byte in byte 9.
// (R10) The product identifier goes low byte in byte 10, high byte in byte 11.
// (R11) Byte 12 holds the power attributes, which also feed the configuration descriptor.
// (R12) Byte 13 holds a current code; enumeration requests twice that many milliamperes.
// (R13) Bytes 14 to 21 hold the eight supplied password bytes, first byte lowest.
// (R14) Byte 7 bits 7 and 1 always read as zero.
`ifndef RSR_CFG_SVH
`define RSR_CFG_SVH

`define RSR_ADDR_W 8
`define RSR_OFS_DAC_CFG 8'h00
`define RSR_OFS_ADC_INT_CFG 8'h04
`define RSR_OFS_USB_ID 8'h08
`define RSR_OFS_USB_PWR 8'h0c
`define RSR_OFS_PWD_LO 8'h10
`define RSR_OFS_PWD_HI 8'h14
`define RSR_OFS_IRQ_STATUS 8'h18
`define RSR_OFS_IRQ_CLEAR 8'h1c
`define RSR_OFS_IRQ_ENABLE 8'h20
`define RSR_OFS_STATE 8'h24

`define RSR_CMD_GET_SETTINGS 8'h61
`define RSR_STATUS_OK 8'h00
`define RSR_RESP_LAST 6'h3f

`define RSR_IDX_CMD 6'h00
`define RSR_IDX_STATUS 6'h01
`define RSR_IDX_DAC 6'h06
`define RSR_IDX_ADC_INT 6'h07
`define RSR_IDX_VID_LO 6'h08
`define RSR_IDX_VID_HI 6'h09
`define RSR_IDX_PID_LO 6'h0a
`define RSR_IDX_PID_HI 6'h0b
`define RSR_IDX_PWR_ATTR 6'h0c
`define RSR_IDX_CURRENT 6'h0d
`define RSR_IDX_PWD_FIRST 6'h0e
`define RSR_IDX_PWD_LAST 6'h15

`define RSR_BIT_NEG_EDGE 6
`define RSR_BIT_POS_EDGE 5
`define RSR_ADC_INT_MASK 8'h7c

`define RSR_IRQ_W 2
`define RSR_IRQ_EDGE 0
`define RSR_IRQ_RESP_DONE 1

`define RSR_RST_DAC_CFG 8'h00
`define RSR_RST_ADC_INT_CFG 8'h00
`define RSR_RST_VID 16'h0000
`define RSR_RST_PID 16'h0000
`define RSR_RST_PWR_ATTR 8'h80
`define RSR_RST_CURRENT 8'h32

`endif

// ### common/rsr_pkg.sv
// Types of the settings report block
package rsr_pkg;

    typedef struct packed {
        logic [1:0] level;
        logic use_internal_voltage_reference;
        logic [4:0] powerup_code;
    } rsr_dac_cfg_t;

    typedef struct packed {
        logic rsvd7;
        logic neg_edge_en;
        logic pos_edge_en;
        logic [1:0] level;
        logic use_internal_voltage_reference;
        logic rsvd1;
        logic rsvd0;
    } rsr_adc_int_cfg_t;

    typedef struct packed {
        rsr_dac_cfg_t dac;
        rsr_adc_int_cfg_t adc_int;
        logic [15:0] vid;
        logic [15:0] pid;
        logic [7:0] power_attr;
        logic [7:0] current_code;
        logic [63:0] password;
    } rsr_settings_t;

    typedef struct packed {
        logic valid;
        logic [5:0] idx;
        logic [7:0] data;
        logic last;
    } rsr_tx_t;

    typedef enum logic [1:0] {
        RSR_IDLE = 2'b01,
        RSR_SEND = 2'b10
    } rsr_state_t;

endpackage : rsr_pkg

// ### rtl/rsr_top.sv
// Run-time settings report assembler with register port and edge interrupt
`timescale 1ns/1ps
`include "rsr_cfg.svh"

module rsr_top (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_b,
    // Register port
    input wire logic [`RSR_ADDR_W-1:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata,
    // Settings request from the host side
    input wire logic i_req,
    input wire logic [7:0] i_req_code,
    // Response byte stream
    output rsr_pkg::rsr_tx_t o_tx,
    // External interrupt input and detect flag
    input wire logic i_ext_int,
    output logic o_int_detect,
    // Enumeration descriptor values
    output logic [7:0] o_cfg_power_attr,
    output logic [8:0] o_cfg_current_ma,
    // Interrupt line
    output logic o_irq
);

    logic [1:0] rst_sync_r;
    logic rst_b;
    rsr_pkg::rsr_settings_t set_r;
    logic [`RSR_IRQ_W-1:0] irq_status_r;
    logic [`RSR_IRQ_W-1:0] irq_enable_r;
    logic [`RSR_IRQ_W-1:0] irq_set;
    logic [`RSR_IRQ_W-1:0] irq_clr;
    logic ext_prev_r;
    logic edge_hit;
    rsr_pkg::rsr_state_t state_r;
    logic [5:0] idx_r;
    logic resp_done;
    logic [31:0] rdata_nxt;

    // Response byte for a given index
    function automatic logic [7:0] resp_byte(input logic [5:0] idx,
                                             input rsr_pkg::rsr_settings_t s);
        logic [2:0] pw;
        pw = 3'(idx - `RSR_IDX_PWD_FIRST);
        resp_byte = 8'h00;
        // (R13) Password bytes in order
        if (idx >= `RSR_IDX_PWD_FIRST && idx <= `RSR_IDX_PWD_LAST) begin
            resp_byte = s.password[pw*8 +: 8];
        end else begin
            unique case (idx)
                // (R1) Echo and status
                `RSR_IDX_CMD: resp_byte = `RSR_CMD_GET_SETTINGS;
                `RSR_IDX_STATUS: resp_byte = `RSR_STATUS_OK;
                // (R2) (R3) (R4) DAC byte
                `RSR_IDX_DAC: resp_byte = s.dac;
                // (R7) (R8) (R14) ADC byte, ignored bits zero
                `RSR_IDX_ADC_INT: resp_byte = s.adc_int & `RSR_ADC_INT_MASK;
                // (R9) Vendor id low first
                `RSR_IDX_VID_LO: resp_byte = s.vid[7:0];
                `RSR_IDX_VID_HI: resp_byte = s.vid[15:8];
                // (R10) Product id low first
                `RSR_IDX_PID_LO: resp_byte = s.pid[7:0];
                `RSR_IDX_PID_HI: resp_byte = s.pid[15:8];
                // (R11) Power attributes
                `RSR_IDX_PWR_ATTR: resp_byte = s.power_attr;
                // (R12) Current code
                `RSR_IDX_CURRENT: resp_byte = s.current_code;
                default: resp_byte = 8'h00;
            endcase
        end
    endfunction : resp_byte

    // Reset release through two flops
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rst_sync_r <= 2'h0;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end
    assign rst_b = rst_sync_r[1];

    // Settings registers
    always_ff @(posedge i_clk or negedge rst_b) begin
        if (!rst_b) begin
            set_r.dac <= `RSR_RST_DAC_CFG;
            set_r.adc_int <= `RSR_RST_ADC_INT_CFG;
            set_r.vid <= `RSR_RST_VID;
            set_r.pid <= `RSR_RST_PID;
            set_r.power_attr <= `RSR_RST_PWR_ATTR;
            set_r.current_code <= `RSR_RST_CURRENT;
            set_r.password <= 64'h0;
        end else if (i_wr) begin
            unique case (i_addr)
                `RSR_OFS_DAC_CFG: set_r.dac <= i_wdata[7:0];
                // (R14) Ignored bits kept at zero
                `RSR_OFS_ADC_INT_CFG: set_r.adc_int <= i_wdata[7:0] & `RSR_ADC_INT_MASK;
                `RSR_OFS_USB_ID: begin
                    set_r.vid <= i_wdata[15:0];
                    set_r.pid <= i_wdata[31:16];
                end
                `RSR_OFS_USB_PWR: begin
                    set_r.power_attr <= i_wdata[7:0];
                    set_r.current_code <= i_wdata[15:8];
                end
                `RSR_OFS_PWD_LO: set_r.password[31:0] <= i_wdata;
                `RSR_OFS_PWD_HI: set_r.password[63:32] <= i_wdata;
                default: ;
            endcase
        end
    end

    // Descriptor values for enumeration
    always_ff @(posedge i_clk or negedge rst_b) begin
        if (!rst_b) begin
            o_cfg_power_attr <= 8'h00;
            o_cfg_current_ma <= 9'h000;
        end else begin
            // (R11) Same attributes to descriptor
            o_cfg_power_attr <= set_r.power_attr;
            // (R12) Twice the code
            o_cfg_current_ma <= {set_r.current_code, 1'b0};
        end
    end

    // Interrupt input edge detection
    always_ff @(posedge i_clk or negedge rst_b) begin
        if (!rst_b) begin
            ext_prev_r <= 1'b0;
        end else begin
            ext_prev_r <= i_ext_int;
        end
    end
    // (R5) (R6) Falling and rising enables
    assign edge_hit = (set_r.adc_int.neg_edge_en & ext_prev_r & ~i_ext_int)
                    | (set_r.adc_int.pos_edge_en & ~ext_prev_r & i_ext_int);

    // Response sequencer
    always_ff @(posedge i_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_r <= rsr_pkg::RSR_IDLE;
            idx_r <= 6'h00;
        end else begin
            unique case (state_r)
                rsr_pkg::RSR_IDLE: begin
                    if (i_req && i_req_code == `RSR_CMD_GET_SETTINGS) begin
                        state_r <= rsr_pkg::RSR_SEND;
                        idx_r <= 6'h00;
                    end
                end
                rsr_pkg::RSR_SEND: begin
                    idx_r <= 6'(idx_r + 6'h01);
                    if (idx_r == `RSR_RESP_LAST) begin
                        state_r <= rsr_pkg::RSR_IDLE;
                    end
                end
                default: state_r <= rsr_pkg::RSR_IDLE;
            endcase
        end
    end
    assign resp_done = (state_r == rsr_pkg::RSR_SEND) && (idx_r == `RSR_RESP_LAST);

    // Response byte output
    always_ff @(posedge i_clk or negedge rst_b) begin
        if (!rst_b) begin
            o_tx <= '0;
        end else begin
            o_tx.valid <= (state_r == rsr_pkg::RSR_SEND);
            o_tx.idx <= idx_r;
            o_tx.data <= (state_r == rsr_pkg::RSR_SEND) ? resp_byte(idx_r, set_r) : 8'h00;
            o_tx.last <= resp_done;
        end
    end

    // Sticky status, set wins over clear
    assign irq_set = {resp_done, edge_hit};
    assign irq_clr = (i_wr && i_addr == `RSR_OFS_IRQ_CLEAR) ? i_wdata[`RSR_IRQ_W-1:0] : '0;
    always_ff @(posedge i_clk or negedge rst_b) begin
        if (!rst_b) begin
            irq_status_r <= '0;
        end else begin
            irq_status_r <= (irq_status_r & ~irq_clr) | irq_set;
        end
    end

    // Interrupt enable
    always_ff @(posedge i_clk or negedge rst_b) begin
        if (!rst_b) begin
            irq_enable_r <= '0;
        end else if (i_wr && i_addr == `RSR_OFS_IRQ_ENABLE) begin
            irq_enable_r <= i_wdata[`RSR_IRQ_W-1:0];
        end
    end

    // Interrupt and detect flag outputs
    always_ff @(posedge i_clk or negedge rst_b) begin
        if (!rst_b) begin
            o_irq <= 1'b0;
            o_int_detect <= 1'b0;
        end else begin
            o_irq <= |(((irq_status_r & ~irq_clr) | irq_set) & irq_enable_r);
            o_int_detect <= (irq_status_r[`RSR_IRQ_EDGE] & ~irq_clr[`RSR_IRQ_EDGE]) | edge_hit;
        end
    end

    // Read decode
    always_comb begin
        rdata_nxt = 32'h0;
        unique case (i_addr)
            `RSR_OFS_DAC_CFG: rdata_nxt = {24'h0, set_r.dac};
            `RSR_OFS_ADC_INT_CFG: rdata_nxt = {24'h0, set_r.adc_int};
            `RSR_OFS_USB_ID: rdata_nxt = {set_r.pid, set_r.vid};
            `RSR_OFS_USB_PWR: rdata_nxt = {16'h0, set_r.current_code, set_r.power_attr};
            `RSR_OFS_PWD_LO: rdata_nxt = set_r.password[31:0];
            `RSR_OFS_PWD_HI: rdata_nxt = set_r.password[63:32];
            `RSR_OFS_IRQ_STATUS: rdata_nxt = {30'h0, irq_status_r};
            `RSR_OFS_IRQ_ENABLE: rdata_nxt = {30'h0, irq_enable_r};
            `RSR_OFS_STATE: rdata_nxt = {24'h0, 2'h0, idx_r} |
                                        {31'h0, state_r == rsr_pkg::RSR_SEND} << 8;
            default: rdata_nxt = 32'h0;
        endcase
    end

    // Read data one cycle later, zero otherwise
    always_ff @(posedge i_clk or negedge rst_b) begin
        if (!rst_b) begin
            o_rdata <= 32'h0;
        end else begin
            o_rdata <= i_rd ? rdata_nxt : 32'h0;
        end
    end

endmodule : rsr_top

// ### verification/rsr_top_assertions.sv
// Port checks of the settings report block
`timescale 1ns/1ps
module rsr_top_chk (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_b,
    // Inputs watched
    input wire logic i_req,
    input wire logic [7:0] i_req_code,
    input wire logic i_ext_int,
    // Outputs watched
    input wire rsr_pkg::rsr_tx_t o_tx,
    input wire logic o_int_detect,
    input wire logic [7:0] o_cfg_power_attr,
    input wire logic [8:0] o_cfg_current_ma
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);
    sequence s_take;
        i_req && i_req_code == 8'h61 && !o_tx.valid && !$past(i_req);
    endsequence
    sequence s_first;
        o_tx.valid && o_tx.idx == 6'h00;
    endsequence
    sequence s_end;
        o_tx.valid && o_tx.last && o_tx.idx == 6'h3f;
    endsequence
    chk_start_echo: assert property (s_take |-> ##2 (s_first and o_tx.data == 8'h61))
        else $error("reply does not open with the echo");
    chk_bad_code: assert property (i_req && i_req_code != 8'h61 && !o_tx.valid && !$past(i_req)
        |-> ##2 !o_tx.valid)
        else $error("reply to a foreign code");
    chk_status_ok: assert property (o_tx.valid && o_tx.idx == 6'h01 |-> o_tx.data == 8'h00)
        else $error("status byte not zero");
    chk_stream_len: assert property (s_first |-> ##63 s_end)
        else $error("reply not 64 bytes");
    chk_idx_step: assert property (o_tx.valid && !o_tx.last
        |=> o_tx.valid && o_tx.idx == $past(o_tx.idx) + 6'h01)
        else $error("reply index gap");
    chk_ignored_bits: assert property (o_tx.valid && o_tx.idx == 6'h07
        |-> o_tx.data[7] == 1'b0 && o_tx.data[1] == 1'b0)
        else $error("ignored bits set");
    chk_attr_copy: assert property (o_tx.valid && o_tx.idx == 6'h0c
        |-> o_cfg_power_attr == o_tx.data)
        else $error("power attributes differ");
    chk_current_double: assert property (o_tx.valid && o_tx.idx == 6'h0d
        |-> o_cfg_current_ma == {o_tx.data, 1'b0})
        else $error("current not doubled");
    chk_edge_cause: assert property ($rose(o_int_detect)
        |-> $past(i_ext_int) != $past(i_ext_int, 2))
        else $error("detect flag without an edge");
endmodule : rsr_top_chk

// ### verification/rsr_host_model.sv
// Host model that sends settings requests and collects the reply
`timescale 1ns/1ps
module rsr_host_model (
    // Clock
    input wire logic i_clk,
    // Request
    output logic o_req,
    output logic [7:0] o_req_code,
    // Reply stream
    input wire rsr_pkg::rsr_tx_t i_tx
);
    logic [7:0] resp [64];
    int n_bytes = 0;
    initial begin
        o_req = 1'b0;
        o_req_code = 8'h00;
    end
    task automatic request(input logic [7:0] code);
        @(posedge i_clk);
        n_bytes <= 0;
        o_req <= 1'b1;
        o_req_code <= code;
        @(posedge i_clk);
        o_req <= 1'b0;
        o_req_code <= ~code;
    endtask : request
    always @(posedge i_clk) begin
        if (i_tx.valid === 1'b1) begin
            resp[i_tx.idx] <= i_tx.data;
            n_bytes <= n_bytes + 1;
        end
    end
endmodule : rsr_host_model

// ### verification/rsr_top_tb.sv
// Self-checking bench of the settings report block
`timescale 1ns/1ps
`include "rsr_cfg.svh"
`define CHK(name, exp, got) begin checked++; if ((got) !== (exp)) begin n_errors++; \
    $display("CHECK FAILED %s exp %0h got %0h", name, exp, got); end end
module rsr_top_tb;
    logic i_clk = 1'b0;
    logic i_rst_b = 1'b0;
    logic [7:0] i_addr = 8'h00;
    logic [31:0] i_wdata = 32'h0;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic i_req;
    logic [7:0] i_req_code;
    logic i_ext_int = 1'b0;
    logic [31:0] o_rdata;
    rsr_pkg::rsr_tx_t o_tx;
    logic o_int_detect;
    logic o_irq;
    logic [7:0] o_cfg_power_attr;
    logic [8:0] o_cfg_current_ma;
    logic [7:0] exp_b [64];
    logic [7:0] dac;
    logic [7:0] adc;
    int n_errors = 0;
    int checked = 0;
    rsr_top i_rsr_top (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_req(i_req), .i_req_code(i_req_code),
        .o_tx(o_tx), .i_ext_int(i_ext_int), .o_int_detect(o_int_detect),
        .o_cfg_power_attr(o_cfg_power_attr), .o_cfg_current_ma(o_cfg_current_ma), .o_irq(o_irq));
    rsr_host_model i_rsr_host_model (.i_clk(i_clk), .o_req(i_req), .o_req_code(i_req_code),
        .i_tx(o_tx));
    initial begin
        forever #4 i_clk = ~i_clk;
    end
    task automatic final_report();
        $display("Comparisons %0d, mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : final_report
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge i_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1;
        `CHK("rdata", e, o_rdata)
    endtask : rd
    task automatic get_resp();
        i_rsr_host_model.request(8'h61);
        for (int k = 0; k < 100 && i_rsr_host_model.n_bytes < 64; k++) begin
            @(posedge i_clk);
        end
        if (i_rsr_host_model.n_bytes != 64) begin
            n_errors++;
            final_report();
        end
        for (int k = 0; k < 64; k++) begin
            `CHK("reply byte", exp_b[k], i_rsr_host_model.resp[k])
        end
    endtask : get_resp
    initial begin
        repeat (6) @(posedge i_clk);
        i_rst_b <= 1'b1;
        repeat (3) @(posedge i_clk);
        rd(`RSR_OFS_ADC_INT_CFG, 32'h0);
        rd(`RSR_OFS_USB_PWR, 32'h3280);
        `CHK("attr", 8'h80, o_cfg_power_attr)
        rd(8'h40, 32'h0);
        wr(`RSR_OFS_USB_ID, 32'h4321_8765);
        wr(`RSR_OFS_USB_PWR, 32'h0000_fac0);
        wr(`RSR_OFS_PWD_LO, 32'h4433_2211);
        wr(`RSR_OFS_PWD_HI, 32'h8877_6655);
        rd(`RSR_OFS_USB_ID, 32'h4321_8765);
        `CHK("current", 9'h1f4, o_cfg_current_ma)
        i_rsr_host_model.request(8'h60);
        repeat (10) @(posedge i_clk);
        `CHK("foreign reply", 0, i_rsr_host_model.n_bytes)
        exp_b = '{default: 8'h00};
        exp_b[0] = 8'h61;
        exp_b[8] = 8'h65;
        exp_b[9] = 8'h87;
        exp_b[10] = 8'h21;
        exp_b[11] = 8'h43;
        exp_b[12] = 8'hc0;
        exp_b[13] = 8'hfa;
        for (int k = 0; k < 8; k++) begin
            exp_b[14 + k] = 8'(8'h11 * (k + 1));
        end
        for (int lv = 0; lv < 4; lv++) begin
            dac = {lv[1:0], lv[0], 5'h0a + 5'(lv)};
            adc = {3'b111, lv[1:0], ~lv[0], 2'b11};
            wr(`RSR_OFS_DAC_CFG, {24'h0, dac});
            wr(`RSR_OFS_ADC_INT_CFG, {24'h0, adc});
            rd(`RSR_OFS_ADC_INT_CFG, {24'h0, adc & 8'h7c});
            exp_b[6] = dac;
            exp_b[7] = adc & 8'h7c;
            get_resp();
        end
        rd(`RSR_OFS_IRQ_STATUS, 32'h2);
        wr(`RSR_OFS_IRQ_CLEAR, 32'h3);
        wr(`RSR_OFS_IRQ_ENABLE, 32'h1);
        wr(`RSR_OFS_ADC_INT_CFG, 32'h40);
        i_ext_int <= 1'b1;
        rd(`RSR_OFS_IRQ_STATUS, 32'h0);
        @(posedge i_clk);
        i_ext_int <= 1'b0;
        rd(`RSR_OFS_IRQ_STATUS, 32'h1);
        `CHK("irq", 1'b1, o_irq)
        wr(`RSR_OFS_IRQ_ENABLE, 32'h0);
        rd(`RSR_OFS_IRQ_STATUS, 32'h1);
        `CHK("irq", 1'b0, o_irq)
        wr(`RSR_OFS_IRQ_CLEAR, 32'h1);
        rd(`RSR_OFS_IRQ_STATUS, 32'h0);
        `CHK("detect", 1'b0, o_int_detect)
        wr(`RSR_OFS_ADC_INT_CFG, 32'h20);
        i_ext_int <= 1'b1;
        rd(`RSR_OFS_IRQ_STATUS, 32'h1);
        `CHK("detect", 1'b1, o_int_detect)
        wr(`RSR_OFS_IRQ_CLEAR, 32'h3);
        wr(`RSR_OFS_IRQ_ENABLE, 32'h2);
        rd(`RSR_OFS_IRQ_ENABLE, 32'h2);
        exp_b[7] = 8'h20;
        get_resp();
        `CHK("irq done", 1'b1, o_irq)
        rd(`RSR_OFS_IRQ_STATUS, 32'h2);
        rd(`RSR_OFS_STATE, 32'h0);
        final_report();
    end
endmodule : rsr_top_tb
bind rsr_top rsr_top_chk i_rsr_top_chk (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_req(i_req),
    .i_req_code(i_req_code), .i_ext_int(i_ext_int), .o_tx(o_tx), .o_int_detect(o_int_detect),
    .o_cfg_power_attr(o_cfg_power_attr), .o_cfg_current_ma(o_cfg_current_ma));
